/* bench/tic_checker.sv */
`timescale 1ns/1ps
module tic_checker
  import tic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // bus handshakes
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic O_BVALID,
  // timers and pins
  input wire logic I_TA_UNDERFLOW,
  input wire logic I_TB_UNDERFLOW,
  input wire logic I_PB6_PORT,
  input wire logic I_PB7_PORT,
  input wire tic_tmr_s O_TA_CTRL,
  input wire tic_tmr_s O_TB_CTRL,
  input wire logic O_PORT_B_PIN_SIX,
  input wire logic O_PORT_B_PIN_SEVEN,
  // interrupt
  input wire logic I_ALARM_EVT,
  input wire logic I_SERIAL_EVT,
  input wire logic I_FLAG_EVT,
  input wire logic O_IRQ_N
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);

  // decode of read handshakes; quiet means no source pulses this cycle
  logic ar_hs, ar_int, quiet, rd_ctrl_ff, nxt_rd_ctrl;
  assign ar_hs = I_ARVALID && O_ARREADY;
  assign ar_int = ar_hs && (I_ARADDR == ADDR_W'(ADDR_INT));
  assign quiet = !(I_TA_UNDERFLOW || I_TB_UNDERFLOW || I_ALARM_EVT
    || I_SERIAL_EVT || I_FLAG_EVT);

  // remembers whether the read in flight targets a control register
  always_comb begin
    nxt_rd_ctrl = rd_ctrl_ff;
    if (!I_NRST) nxt_rd_ctrl = 1'b0;
    else if (ar_hs) nxt_rd_ctrl = (I_ARADDR == ADDR_W'(ADDR_CTRL_A))
      || (I_ARADDR == ADDR_W'(ADDR_CTRL_B));
  end
  always_ff @(posedge I_CLK_SYS) begin
    rd_ctrl_ff <= nxt_rd_ctrl;
  end

  a_load_a_pulse: assert property (O_TA_CTRL.load |=> !O_TA_CTRL.load)
    else $error("timer a load strobe longer than one cycle");
  a_load_b_pulse: assert property (O_TB_CTRL.load |=> !O_TB_CTRL.load)
    else $error("timer b load strobe longer than one cycle");
  a_load_reads_zero: assert property (
    O_RVALID && rd_ctrl_ff |-> !O_RDATA[4])
    else $error("load bit read back as one");
  a_pin_six_route: assert property (I_NRST |=> O_PORT_B_PIN_SIX ==
    ($past(O_TA_CTRL.port_pin) ? $past(O_TA_CTRL.level) : $past(I_PB6_PORT)))
    else $error("pin six source wrong");
  a_pin_seven_route: assert property (I_NRST |=> O_PORT_B_PIN_SEVEN ==
    ($past(O_TB_CTRL.port_pin) ? $past(O_TB_CTRL.level) : $past(I_PB7_PORT)))
    else $error("pin seven source wrong");
  a_one_shot_stop: assert property (I_TA_UNDERFLOW && O_TA_CTRL.start
    && O_TA_CTRL.one_shot && !I_AWVALID && O_AWREADY
    |-> ##[1:2] !O_TA_CTRL.start)
    else $error("one shot underflow left timer a running");
  a_read_releases: assert property (ar_int && quiet |=> O_IRQ_N)
    else $error("interrupt line held after data read");
  a_summary_bit: assert property (ar_int |=>
    O_RDATA[BIT_SUMMARY] == !$past(O_IRQ_N) && O_RDATA[6:5] == 2'h0)
    else $error("summary bit disagrees with interrupt line");
  a_irq_fall_cause: assert property ($fell(O_IRQ_N) |->
    !$past(quiet) || $rose(O_BVALID))
    else $error("interrupt line fell without source or mask write");

  c_int_read_pending: cover property (ar_int && !O_IRQ_N);
  c_one_shot: cover property (I_TA_UNDERFLOW && O_TA_CTRL.one_shot);
  c_load_b: cover property (O_TB_CTRL.load);
endmodule

bind tic_timer_interrupt_control tic_checker #(.ADDR_W(ADDR_W))
  tic_checker_i (.*);

/* bench/tic_evt_model.sv */
`timescale 1ns/1ps
module tic_evt_model
  import tic_pkg::*;
(
  // clock
  input wire logic i_clk,
  // requested events, one bit per source
  input wire logic [INT_SRC_W-1:0] i_fire,
  // one-cycle event pulses toward the block
  output logic [INT_SRC_W-1:0] o_evt
);
  // registered so each pulse starts just after an edge and lasts one cycle
  always_ff @(posedge i_clk) begin
    o_evt <= i_fire;
  end
endmodule

/* bench/tic_timer_interrupt_control_tb.sv */
`timescale 1ns/1ps
module tic_timer_interrupt_control_tb
  import tic_pkg::*;
;
  logic I_CLK_SYS, I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [7:0] I_AWADDR, I_ARADDR, d, g;
  logic [31:0] I_WDATA, O_RDATA;
  logic [3:0] I_WSTRB;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0] O_BRESP, O_RRESP, O_TB_COUNT_SRC;
  logic I_COUNT_PIN, I_PB6_PORT, I_PB7_PORT, O_PORT_B_PIN_SIX;
  tic_tmr_s O_TA_CTRL, O_TB_CTRL;
  logic O_PORT_B_PIN_SEVEN, O_TA_COUNT_SRC, O_SERIAL_DIR_OUT, O_MAINS_50HZ;
  logic O_TOD_WRITE_ALARM, O_IRQ_N, O_IRQ;
  logic [4:0] fire, evt;
  logic [1:0] ld_seen = 2'h0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int tk_a = 0;
  int tk_b = 0;
  int na, nb;

  tic_evt_model tic_evt_model_i (.i_clk(I_CLK_SYS), .i_fire(fire),
    .o_evt(evt));
  tic_timer_interrupt_control tic_timer_interrupt_control_i (.*,
    .I_TA_UNDERFLOW(evt[0]), .I_TB_UNDERFLOW(evt[1]), .I_ALARM_EVT(evt[2]),
    .I_SERIAL_EVT(evt[3]), .I_FLAG_EVT(evt[4]));

  // 40 MHz system clock
  always #12.5 I_CLK_SYS = ~I_CLK_SYS;

  // load strobes are one cycle wide: latch them; count every cycle that a count enable is high
  always @(posedge I_CLK_SYS) begin
    if (I_NRST) begin
      ld_seen <= ld_seen | {O_TB_CTRL.load, O_TA_CTRL.load};
      if (O_TA_CTRL.tick) tk_a <= tk_a + 1;
      if (O_TB_CTRL.tick) tk_b <= tk_b + 1;
    end
  end

  // hang guard: the whole run needs only a few hundred cycles
  always @(posedge I_CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write master: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge I_CLK_SYS);
    I_AWADDR <= a;
    I_WDATA <= {24'h0, v};
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    while (!done) begin
      @(posedge I_CLK_SYS);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID) begin
        chk({30'h0, O_BRESP}, {30'h0, er});
        I_BREADY <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge I_CLK_SYS);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    while (!done) begin
      @(posedge I_CLK_SYS);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID) begin
        chk(O_RDATA, e);
        chk({30'h0, O_RRESP}, {30'h0, er});
        I_RREADY <= 1'b0;
        done = 1;
      end
    end
  endtask

  // one-cycle pulse on the chosen sources, then let flags settle
  task automatic pulse(input logic [4:0] v);
    @(posedge I_CLK_SYS);
    fire <= v;
    @(posedge I_CLK_SYS);
    fire <= 5'h00;
    repeat (3) @(posedge I_CLK_SYS);
    #1;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    I_CLK_SYS = 1'b0;
    I_NRST = 1'b0;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
    I_AWADDR = 8'h00;
    I_ARADDR = 8'h00;
    I_WDATA = 32'h0;
    I_WSTRB = 4'hF;
    {I_COUNT_PIN, I_PB6_PORT, I_PB7_PORT} = 3'h0;
    fire = 5'h00;
    repeat (10) @(posedge I_CLK_SYS);
    I_NRST <= 1'b1;
    repeat (2) @(posedge I_CLK_SYS);
    // reset contents and an unmapped place
    rd(ADDR_CTRL_A, 32'h0, RESP_OKAY);
    rd(ADDR_CTRL_B, 32'h0, RESP_OKAY);
    rd(ADDR_INT, 32'h0, RESP_OKAY);
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h08, 8'hFF, RESP_SLVERR);
    chk({31'h0, O_IRQ_N}, 32'h1);
    tend("reset");
    // flags set regardless of mask; read clears; set and clear of mask
    wr(ADDR_INT, 8'h1F, RESP_OKAY);
    pulse(5'h1F);
    chk({31'h0, O_IRQ_N}, 32'h1);
    rd(ADDR_INT, 32'h1F, RESP_OKAY);
    rd(ADDR_INT, 32'h00, RESP_OKAY);
    wr(ADDR_INT, 8'h81, RESP_OKAY);
    pulse(5'h04);
    chk({31'h0, O_IRQ_N}, 32'h1);
    pulse(5'h01);
    chk({31'h0, O_IRQ_N}, 32'h0);
    rd(ADDR_INT, 32'h85, RESP_OKAY);
    #1;
    chk({31'h0, O_IRQ_N}, 32'h1);
    wr(ADDR_INT, 8'h84, RESP_OKAY);
    wr(ADDR_INT, 8'h01, RESP_OKAY);
    pulse(5'h01);
    chk({31'h0, O_IRQ_N}, 32'h1);
    pulse(5'h04);
    chk({31'h0, O_IRQ_N}, 32'h0);
    rd(ADDR_INT, 32'h85, RESP_OKAY);
    wr(ADDR_INT, 8'h1F, RESP_OKAY);
    tend("interrupt");
    // every control field of both timers, all four source codes of b
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 9; i++) begin
        d = (i < 8) ? (8'h01 << i) : 8'h60;
        wr(t ? ADDR_CTRL_B : ADDR_CTRL_A, d, RESP_OKAY);
        d = d & 8'hEF; // the load strobe always reads back as zero
        rd(t ? ADDR_CTRL_B : ADDR_CTRL_A, {24'h0, d}, RESP_OKAY);
        g = t ? {O_TOD_WRITE_ALARM, O_TB_COUNT_SRC, 1'b0, O_TB_CTRL.one_shot,
                 O_TB_CTRL.toggle, O_TB_CTRL.port_pin, O_TB_CTRL.start}
              : {O_MAINS_50HZ, O_SERIAL_DIR_OUT, O_TA_COUNT_SRC, 1'b0,
                 O_TA_CTRL.one_shot, O_TA_CTRL.toggle, O_TA_CTRL.port_pin,
                 O_TA_CTRL.start};
        chk({24'h0, g}, {24'h0, d});
      end
    end
    chk({30'h0, ld_seen}, 32'h3);
    tend("control");
    // port b pins: normal function, then timer outputs with a toggle
    I_PB6_PORT <= 1'b1;
    I_PB7_PORT <= 1'b1;
    wr(ADDR_CTRL_A, 8'h00, RESP_OKAY);
    wr(ADDR_CTRL_B, 8'h00, RESP_OKAY);
    pulse(5'h00);
    chk({30'h0, O_PORT_B_PIN_SEVEN, O_PORT_B_PIN_SIX}, 32'h3);
    wr(ADDR_CTRL_A, 8'h07, RESP_OKAY);
    wr(ADDR_CTRL_B, 8'h02, RESP_OKAY);
    pulse(5'h00);
    chk({30'h0, O_PORT_B_PIN_SEVEN, O_PORT_B_PIN_SIX}, 32'h0);
    pulse(5'h01);
    chk({30'h0, O_PORT_B_PIN_SEVEN, O_PORT_B_PIN_SIX}, 32'h1);
    tend("pins");
    // one-shot stops both timers, continuous keeps running
    wr(ADDR_EVT_STAT, 8'h07, RESP_OKAY);
    wr(ADDR_EVT_MASK, 8'h01, RESP_OKAY);
    wr(ADDR_CTRL_A, 8'h09, RESP_OKAY);
    wr(ADDR_CTRL_B, 8'h09, RESP_OKAY);
    pulse(5'h03);
    rd(ADDR_CTRL_A, 32'h08, RESP_OKAY);
    rd(ADDR_CTRL_B, 32'h08, RESP_OKAY);
    rd(ADDR_EVT_STAT, 32'h03, RESP_OKAY);
    chk({31'h0, O_IRQ}, 32'h1);
    wr(ADDR_EVT_STAT, 8'h01, RESP_OKAY);
    rd(ADDR_EVT_STAT, 32'h02, RESP_OKAY);
    #1;
    chk({31'h0, O_IRQ}, 32'h0);
    wr(ADDR_CTRL_A, 8'h01, RESP_OKAY);
    pulse(5'h01);
    rd(ADDR_CTRL_A, 32'h01, RESP_OKAY);
    tend("one shot");
    // count sources: clock, count pin edges for a, timer a underflow for b
    wr(ADDR_CTRL_A, 8'h01, RESP_OKAY);
    wr(ADDR_CTRL_B, 8'h01, RESP_OKAY);
    #1;
    chk({30'h0, O_TB_CTRL.tick, O_TA_CTRL.tick}, 32'h3);
    wr(ADDR_CTRL_A, 8'h21, RESP_OKAY);
    wr(ADDR_CTRL_B, 8'h41, RESP_OKAY);
    pulse(5'h00);
    na = tk_a;
    nb = tk_b;
    chk({30'h0, O_TB_CTRL.tick, O_TA_CTRL.tick}, 32'h0);
    @(posedge I_CLK_SYS);
    I_COUNT_PIN <= 1'b1;
    pulse(5'h01);
    chk(tk_a - na, 32'h1);
    chk(tk_b - nb, 32'h1);
    tend("sources");
    test_done();
  end
endmodule

/* hw/tic_pkg.sv */
package tic_pkg;

  // register word indices; the byte address is four times the index
  localparam logic [3:0] IDX_INT = 4'hD;
  localparam logic [3:0] IDX_CTRL_A = 4'hE;
  localparam logic [3:0] IDX_CTRL_B = 4'hF;
  localparam logic [7:0] ADDR_INT = {2'h0, IDX_INT, 2'h0};
  localparam logic [7:0] ADDR_CTRL_A = {2'h0, IDX_CTRL_A, 2'h0};
  localparam logic [7:0] ADDR_CTRL_B = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [7:0] ADDR_EVT_STAT = 8'h40;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h44;

  // timer control field positions, shared by both timers except BIT_SERIAL and BIT_MAINS (a only) and BIT_ALARM (b only); b's source spans bits 6:5
  localparam int BIT_START = 0;
  localparam int BIT_PORT_PIN = 1;
  localparam int BIT_TOGGLE = 2;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_LOAD = 4;
  localparam int BIT_SRC = 5;
  localparam int BIT_SERIAL = 6;
  localparam int BIT_MAINS = 7;
  localparam int BIT_ALARM = 7;

  // interrupt data / mask layout
  localparam int INT_SRC_W = 5;
  localparam int BIT_SUMMARY = 7;
  localparam int BIT_SET_CLEAR = 7;

  // event status layout (sticky, write one to clear)
  localparam int EVT_W = 3;
  localparam int EVT_TA_STOP = 0;
  localparam int EVT_TB_STOP = 1;
  localparam int EVT_REQUEST = 2;

  // timer b count source codes
  localparam logic [1:0] SRC_PHI2 = 2'h0;
  localparam logic [1:0] SRC_COUNT_PIN = 2'h1;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [INT_SRC_W-1:0] RST_INT = 5'h00;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic start;
    logic port_pin;
    logic toggle;
    logic one_shot;
    logic load;
    logic tick;
    logic level;
  } tic_tmr_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_A = 2'b01,
    WR_HAVE_D = 2'b10,
    WR_RESP = 2'b11
  } tic_wr_e;

endpackage

/* hw/tic_timer_interrupt_control.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tic_timer_interrupt_control
  import tic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // axi4-lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // timer datapath and pins
  input wire logic I_TA_UNDERFLOW,
  input wire logic I_TB_UNDERFLOW,
  input wire logic I_COUNT_PIN,
  input wire logic I_PB6_PORT,
  input wire logic I_PB7_PORT,
  output tic_tmr_s O_TA_CTRL,
  output tic_tmr_s O_TB_CTRL,
  output logic O_PORT_B_PIN_SIX,
  output logic O_PORT_B_PIN_SEVEN,
  // mode outputs: count sources, serial port and time of day
  output logic O_TA_COUNT_SRC,
  output logic O_SERIAL_DIR_OUT,
  output logic O_MAINS_50HZ,
  output logic [1:0] O_TB_COUNT_SRC,
  output logic O_TOD_WRITE_ALARM,
  // interrupt sources, one-cycle pulses
  input wire logic I_ALARM_EVT,
  input wire logic I_SERIAL_EVT,
  input wire logic I_FLAG_EVT,
  // interrupt outputs
  output logic O_IRQ_N,
  output logic O_IRQ
);

  // aligned byte address: the low two address bits cleared
  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = 8'h00;
    w[7:2] = a[7:2];
    return w;
  endfunction

  // write channel state
  tic_wr_e wr_st_ff, nxt_wr_st;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic do_wr;

  // read channel state
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic do_rd;
  logic [7:0] raddr;

  // upper control bits held here
  logic ta_src_ff, nxt_ta_src;
  logic serial_ff, nxt_serial;
  logic mains_ff, nxt_mains;
  logic [1:0] tb_src_ff, nxt_tb_src;
  logic alarm_ff, nxt_alarm;

  // interrupt state
  logic [INT_SRC_W-1:0] flags_ff, nxt_flags;
  logic [INT_SRC_W-1:0] mask_ff, nxt_mask;
  logic irq_n_ff, nxt_irq_n;
  logic [EVT_W-1:0] evt_ff, nxt_evt;
  logic [EVT_W-1:0] evt_mask_ff, nxt_evt_mask;
  logic irq_ff, nxt_irq;
  logic [INT_SRC_W-1:0] sources;
  logic summary;

  // count pin edge detection and source selection
  logic cnt_q_ff;
  logic cnt_rise;
  logic ta_tick_src;
  logic tb_tick_src;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic ta_stop_evt;
  logic tb_stop_evt;

  assign do_wr = (wr_st_ff == WR_RESP) && !bvalid_ff;
  assign do_rd = I_ARVALID && arready_ff;
  assign raddr = word_addr(I_ARADDR);
  assign wr_ctrl_a = do_wr && wstrb_ff && (waddr_ff == ADDR_CTRL_A);
  assign wr_ctrl_b = do_wr && wstrb_ff && (waddr_ff == ADDR_CTRL_B);
  assign cnt_rise = I_COUNT_PIN && !cnt_q_ff;

  // timer a: clock pulses or count pin rising edges
  assign ta_tick_src = ta_src_ff ? cnt_rise : 1'b1;
  // timer b: clock, count pin, or timer a underflow (both upper codes)
  always_comb begin
    case (tb_src_ff)
      SRC_PHI2: tb_tick_src = 1'b1;
      SRC_COUNT_PIN: tb_tick_src = cnt_rise;
      default: tb_tick_src = I_TA_UNDERFLOW;
    endcase
  end

  // write channel: address and data taken in either order, then answered
  always_comb begin
    nxt_wr_st = wr_st_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (I_AWVALID && awready_ff) begin
      nxt_waddr = word_addr(I_AWADDR);
    end
    if (I_WVALID && wready_ff) begin
      nxt_wdata = I_WDATA[7:0];
      nxt_wstrb = I_WSTRB[0];
    end
    case (wr_st_ff)
      WR_IDLE: begin
        if (I_AWVALID && awready_ff && I_WVALID && wready_ff) begin
          nxt_wr_st = WR_RESP;
        end else if (I_AWVALID && awready_ff) begin
          nxt_wr_st = WR_HAVE_A;
        end else if (I_WVALID && wready_ff) begin
          nxt_wr_st = WR_HAVE_D;
        end
      end
      WR_HAVE_A: begin
        if (I_WVALID && wready_ff) begin
          nxt_wr_st = WR_RESP;
        end
      end
      WR_HAVE_D: begin
        if (I_AWVALID && awready_ff) begin
          nxt_wr_st = WR_RESP;
        end
      end
      WR_RESP: begin
        if (do_wr) begin
          nxt_bvalid = 1'b1;
          case (waddr_ff)
            ADDR_INT, ADDR_CTRL_A, ADDR_CTRL_B,
            ADDR_EVT_STAT, ADDR_EVT_MASK: nxt_bresp = RESP_OKAY;
            default: nxt_bresp = RESP_SLVERR;
          endcase
        end else if (bvalid_ff && I_BREADY) begin
          nxt_bvalid = 1'b0;
          nxt_wr_st = WR_IDLE;
        end
      end
      default: nxt_wr_st = WR_IDLE;
    endcase
    // readies follow the next state so they are plain flip-flops
    nxt_awready = (nxt_wr_st == WR_IDLE) || (nxt_wr_st == WR_HAVE_D);
    nxt_wready = (nxt_wr_st == WR_IDLE) || (nxt_wr_st == WR_HAVE_A);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      wr_st_ff <= WR_IDLE;
      waddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      wr_st_ff <= nxt_wr_st;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // read channel: one cycle to the answer, one read outstanding
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (do_rd) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (raddr)
        // the mask is write-only; this address reads the flags
        ADDR_INT: nxt_rdata = {24'h000000, summary, 2'h0, flags_ff};
        ADDR_CTRL_A: nxt_rdata = {24'h000000, mains_ff, serial_ff,
          ta_src_ff, 1'b0, O_TA_CTRL.one_shot, O_TA_CTRL.toggle,
          O_TA_CTRL.port_pin, O_TA_CTRL.start};
        ADDR_CTRL_B: nxt_rdata = {24'h000000, alarm_ff, tb_src_ff,
          1'b0, O_TB_CTRL.one_shot, O_TB_CTRL.toggle,
          O_TB_CTRL.port_pin, O_TB_CTRL.start};
        ADDR_EVT_STAT: nxt_rdata = {29'h00000000, evt_ff};
        ADDR_EVT_MASK: nxt_rdata = {29'h00000000, evt_mask_ff};
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && I_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // upper control bits of both timers
  always_comb begin
    nxt_ta_src = ta_src_ff;
    nxt_serial = serial_ff;
    nxt_mains = mains_ff;
    nxt_tb_src = tb_src_ff;
    nxt_alarm = alarm_ff;
    if (wr_ctrl_a) begin
      nxt_ta_src = wdata_ff[BIT_SRC];
      nxt_serial = wdata_ff[BIT_SERIAL];
      nxt_mains = wdata_ff[BIT_MAINS];
    end
    if (wr_ctrl_b) begin
      nxt_tb_src = wdata_ff[BIT_SERIAL:BIT_SRC];
      nxt_alarm = wdata_ff[BIT_ALARM];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      ta_src_ff <= RST_CTRL[BIT_SRC];
      serial_ff <= RST_CTRL[BIT_SERIAL];
      mains_ff <= RST_CTRL[BIT_MAINS];
      tb_src_ff <= RST_CTRL[BIT_SERIAL:BIT_SRC];
      alarm_ff <= RST_CTRL[BIT_ALARM];
      cnt_q_ff <= 1'b1; // pin idles high, so no false edge at release
    end else begin
      ta_src_ff <= nxt_ta_src;
      serial_ff <= nxt_serial;
      mains_ff <= nxt_mains;
      tb_src_ff <= nxt_tb_src;
      alarm_ff <= nxt_alarm;
      cnt_q_ff <= I_COUNT_PIN;
    end
  end

  // one unit per timer for the low five control bits
  tic_timer_unit u_timer_a (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_wr(wr_ctrl_a),
    .i_wdata(wdata_ff[4:0]),
    .i_underflow(I_TA_UNDERFLOW),
    .i_src_tick(ta_tick_src),
    .i_port_normal(I_PB6_PORT),
    .o_ctl(O_TA_CTRL),
    .o_pin(O_PORT_B_PIN_SIX),
    .o_stop_evt(ta_stop_evt)
  );

  tic_timer_unit u_timer_b (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_wr(wr_ctrl_b),
    .i_wdata(wdata_ff[4:0]),
    .i_underflow(I_TB_UNDERFLOW),
    .i_src_tick(tb_tick_src),
    .i_port_normal(I_PB7_PORT),
    .o_ctl(O_TB_CTRL),
    .o_pin(O_PORT_B_PIN_SEVEN),
    .o_stop_evt(tb_stop_evt)
  );

  assign sources = {I_FLAG_EVT, I_SERIAL_EVT, I_ALARM_EVT,
    I_TB_UNDERFLOW, I_TA_UNDERFLOW};
  assign summary = |(flags_ff & mask_ff);

  // interrupt flags, mask and request; a new event beats the read clear
  always_comb begin
    nxt_flags = flags_ff;
    nxt_mask = mask_ff;
    nxt_evt = evt_ff;
    nxt_evt_mask = evt_mask_ff;
    if (do_rd && (raddr == ADDR_INT)) begin
      nxt_flags = RST_INT;
    end
    nxt_flags = nxt_flags | sources;
    if (do_wr && wstrb_ff && (waddr_ff == ADDR_INT)) begin
      if (wdata_ff[BIT_SET_CLEAR]) begin
        nxt_mask = mask_ff | wdata_ff[INT_SRC_W-1:0];
      end else begin
        nxt_mask = mask_ff & ~wdata_ff[INT_SRC_W-1:0];
      end
    end
    if (do_wr && wstrb_ff && (waddr_ff == ADDR_EVT_STAT)) begin
      nxt_evt = evt_ff & ~wdata_ff[EVT_W-1:0];
    end
    if (do_wr && wstrb_ff && (waddr_ff == ADDR_EVT_MASK)) begin
      nxt_evt_mask = wdata_ff[EVT_W-1:0];
    end
    // request line low while any unmasked flag stands
    nxt_irq_n = !(|(nxt_flags & nxt_mask));
    // sticky events set after the clear so the set wins
    nxt_evt[EVT_TA_STOP] = nxt_evt[EVT_TA_STOP] | ta_stop_evt;
    nxt_evt[EVT_TB_STOP] = nxt_evt[EVT_TB_STOP] | tb_stop_evt;
    nxt_evt[EVT_REQUEST] = nxt_evt[EVT_REQUEST] | (irq_n_ff & !nxt_irq_n);
    nxt_irq = |(nxt_evt & nxt_evt_mask);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      flags_ff <= RST_INT;
      mask_ff <= RST_INT;
      irq_n_ff <= 1'b1;
      evt_ff <= RST_EVT;
      evt_mask_ff <= RST_EVT;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      irq_n_ff <= nxt_irq_n;
      evt_ff <= nxt_evt;
      evt_mask_ff <= nxt_evt_mask;
      irq_ff <= nxt_irq;
    end
  end

  // port hookup, every one from a flip-flop
  assign O_AWREADY = awready_ff;
  assign O_WREADY = wready_ff;
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;
  assign O_TA_COUNT_SRC = ta_src_ff;
  assign O_SERIAL_DIR_OUT = serial_ff;
  assign O_MAINS_50HZ = mains_ff;
  assign O_TB_COUNT_SRC = tb_src_ff;
  assign O_TOD_WRITE_ALARM = alarm_ff;
  assign O_IRQ_N = irq_n_ff;
  assign O_IRQ = irq_ff;

endmodule

/* hw/tic_timer_unit.sv */
`timescale 1ns/1ps
module tic_timer_unit
  import tic_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register write
  input wire logic i_wr,
  input wire logic [4:0] i_wdata,
  // timer datapath
  input wire logic i_underflow,
  input wire logic i_src_tick,
  input wire logic i_port_normal,
  // outputs
  output tic_tmr_s o_ctl,
  output logic o_pin,
  output logic o_stop_evt
);

  tic_tmr_s ctl_ff, nxt_ctl;
  logic pin_ff, nxt_pin;
  logic stop_ff, nxt_stop;

  // control bits, strobes and timer output shaping
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_stop = 1'b0;
    nxt_ctl.load = 1'b0;
    // one-shot underflow stops the timer; a write in the same cycle wins
    if (i_underflow && ctl_ff.one_shot && ctl_ff.start) begin
      nxt_ctl.start = 1'b0;
      nxt_stop = 1'b1;
    end
    if (i_wr) begin
      nxt_ctl.start = i_wdata[BIT_START];
      nxt_ctl.port_pin = i_wdata[BIT_PORT_PIN];
      nxt_ctl.toggle = i_wdata[BIT_TOGGLE];
      nxt_ctl.one_shot = i_wdata[BIT_ONE_SHOT];
      nxt_ctl.load = i_wdata[BIT_LOAD];
    end
    // count enable only while running, from the selected source
    nxt_ctl.tick = nxt_ctl.start & i_src_tick;
    // toggle flips per underflow, pulse style copies the underflow
    if (ctl_ff.toggle) begin
      nxt_ctl.level = ctl_ff.level ^ i_underflow;
    end else begin
      nxt_ctl.level = i_underflow;
    end
    nxt_pin = ctl_ff.port_pin ? ctl_ff.level : i_port_normal;
  end

  // registers; pin mux costs one cycle so the pin is glitch free
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctl_ff <= '0;
      pin_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      ctl_ff <= nxt_ctl;
      pin_ff <= nxt_pin;
      stop_ff <= nxt_stop;
    end
  end

  assign o_ctl = ctl_ff;
  assign o_pin = pin_ff;
  assign o_stop_evt = stop_ff;

endmodule
